/* File: hdl/i2c_slave_address_data_status.sv */
// two-wire slave: address match, direction flag, acknowledge flag, shared data and own address
// assumes an external master drives the clock line; the data line is open drain
`timescale 1ns/1ps
module i2c_slave_address_data_status (
   input wire logic clk_sys,
   input wire logic rst,
   input wire i2c_slave_pkg::avs_req_t avsReq,
   output i2c_slave_pkg::avs_rsp_t avsRsp,
   input wire i2c_slave_pkg::pins_t pinIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic irq,
   output logic wakeReq
);
   import i2c_slave_pkg::*;

   // ==========================================================
   // pin sampling and bus conditions
   pins_t pinS;
   logic sclD_q, sdaD_q;
   pin_sync #(.WIDTH(2)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .din({pinIn.scl, pinIn.sda}),
      .dout({pinS.scl, pinS.sda})
   );
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclD_q <= 1'b1;
         sdaD_q <= 1'b1;
      end else begin
         sclD_q <= pinS.scl;
         sdaD_q <= pinS.sda;
      end
   end
   wire sclRise = pinS.scl & ~sclD_q;
   wire sclFall = ~pinS.scl & sclD_q;
   wire startCond = pinS.scl & sclD_q & sdaD_q & ~pinS.sda;
   wire stopCond = pinS.scl & sclD_q & ~sdaD_q & pinS.sda;

   // ==========================================================
   // state
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_TXNEXT, ST_WAIT} state_t;
   state_t state_q, state_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] dataReg_q;
   logic [7:1] ownAddr_q;
   logic ownBit0_q;
   logic dirFlag_q, ackFlag_q, hitFlag_q, wakeEn_q;
   logic [EV_W-1:0] evStat_q, evMask_q;
   logic sdaOe_d;
   logic [7:0] shQ;

   wire addrLast = (state_q == ST_ADDR) & sclRise & (bitCnt_q == ADDR_BITS);
   wire addrMatch = (shQ[6:0] == ownAddr_q[7:1]);
   wire hitEv = addrLast & addrMatch;
   wire rxLast = (state_q == ST_RX) & sclRise & (bitCnt_q == BITS_PER_BYTE - 4'h1);
   wire txAckRise = (state_q == ST_TXACK) & sclRise;
   wire nackEv = txAckRise & pinS.sda;
   wire ackSecond = (state_q == ST_ACK) & sclFall & sdaOe;
   wire txLoad = (ackSecond & dirFlag_q) | ((state_q == ST_TXNEXT) & sclFall);
   wire txShift = (state_q == ST_TX) & sclFall & (bitCnt_q != BITS_PER_BYTE);
   wire rxShift = ((state_q == ST_ADDR) | (state_q == ST_RX)) & sclRise;

   shift_byte u_shift (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(txLoad),
      .loadVal({dataReg_q[6:0], 1'b0}),
      .shiftEn(rxShift | txShift),
      .bitIn(pinS.sda),
      .q(shQ)
   );

   // ==========================================================
   // bit-level sequencer
   always_comb begin
      state_d = state_q;
      bitCnt_d = bitCnt_q;
      sdaOe_d = sdaOe;
      if (startCond) begin
         state_d = ST_ADDR;
         bitCnt_d = 4'h0;
         sdaOe_d = 1'b0;
      end else if (stopCond) begin
         state_d = ST_IDLE;
         sdaOe_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE, ST_WAIT: begin
            end
            ST_ADDR: begin
               if (sclRise) begin
                  bitCnt_d = bitCnt_q + 4'h1;
                  if (addrLast) begin
                     state_d = addrMatch ? ST_ACK : ST_WAIT;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  if (!sdaOe) begin
                     sdaOe_d = 1'b1;
                  end else if (dirFlag_q) begin
                     state_d = ST_TX;
                     sdaOe_d = ~dataReg_q[7];
                     bitCnt_d = 4'h1;
                  end else begin
                     state_d = ST_RX;
                     sdaOe_d = 1'b0;
                     bitCnt_d = 4'h0;
                  end
               end
            end
            ST_RX: begin
               if (sclRise) begin
                  bitCnt_d = bitCnt_q + 4'h1;
                  if (rxLast) begin
                     state_d = ST_ACK;
                  end
               end
            end
            ST_TX: begin
               if (sclFall) begin
                  if (bitCnt_q == BITS_PER_BYTE) begin
                     sdaOe_d = 1'b0;
                     state_d = ST_TXACK;
                  end else begin
                     sdaOe_d = ~shQ[7];
                     bitCnt_d = bitCnt_q + 4'h1;
                  end
               end
            end
            ST_TXACK: begin
               if (sclRise) begin
                  state_d = pinS.sda ? ST_WAIT : ST_TXNEXT;
               end
            end
            ST_TXNEXT: begin
               if (sclFall) begin
                  state_d = ST_TX;
                  sdaOe_d = ~dataReg_q[7];
                  bitCnt_d = 4'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         bitCnt_q <= 4'h0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
      end else begin
         state_q <= state_d;
         bitCnt_q <= bitCnt_d;
         sdaOe <= sdaOe_d;
         sdaOut <= 1'b0;
      end
   end

   // ==========================================================
   // register bus decode
   logic waitQ;
   wire busReq = avsReq.read | avsReq.write;
   wire wrTake = avsReq.write & ~waitQ;
   wire rdTake = avsReq.read & ~waitQ;
   wire wrData = wrTake & (avsReq.address == OFS_DATA);
   wire wrAddr = wrTake & (avsReq.address == OFS_ADDR);
   wire wrCtrl = wrTake & (avsReq.address == OFS_CTRL);
   wire wrMask = wrTake & (avsReq.address == OFS_MASK);
   wire rdStat = rdTake & (avsReq.address == OFS_STAT);
   wire [7:0] ctrlView = {4'h0, hitFlag_q, dirFlag_q, wakeEn_q, ackFlag_q};
   wire [31:0] rdMux =
      (avsReq.address == OFS_DATA) ? {24'h0, dataReg_q} :
      (avsReq.address == OFS_ADDR) ? {24'h0, ownAddr_q, ownBit0_q} :
      (avsReq.address == OFS_CTRL) ? {24'h0, ctrlView} :
      (avsReq.address == OFS_STAT) ? {29'h0, evStat_q} :
      (avsReq.address == OFS_MASK) ? {29'h0, evMask_q} : READ_UNMAPPED;
   wire [EV_W-1:0] evSet = {nackEv, rxLast, hitEv};
   // a status read clears only the bits it reported, so an event landing between capture and clear is kept
   wire [EV_W-1:0] evClr = rdStat ? avsRsp.readdata[EV_W-1:0] : RST_EV;
   wire [EV_W-1:0] evNext = (evStat_q & ~evClr) | evSet;

   // waitrequest is a copy of waitQ kept in this process, so the response struct has one driver
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         waitQ <= 1'b1;
         avsRsp.waitrequest <= 1'b1;
         avsRsp.readdata <= 32'h0000_0000;
      end else begin
         waitQ <= ~(busReq & waitQ);
         avsRsp.waitrequest <= ~(busReq & waitQ);
         if (avsReq.read & waitQ) begin
            avsRsp.readdata <= rdMux;
         end
      end
   end

   // ==========================================================
   // registers and flags
   always_ff @(posedge clk_sys) begin
      if (rxLast) begin
         dataReg_q <= {shQ[6:0], pinS.sda};
      end else if (wrData) begin
         dataReg_q <= avsReq.writedata[7:0];
      end
      if (wrAddr) begin
         ownAddr_q <= avsReq.writedata[7:1];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ownBit0_q <= RST_ADDR_BIT0;
         wakeEn_q <= RST_WAKE;
         ackFlag_q <= RST_ACK;
         dirFlag_q <= 1'b0;
         hitFlag_q <= 1'b0;
         evStat_q <= RST_EV;
         evMask_q <= RST_EV;
         irq <= 1'b0;
         wakeReq <= 1'b0;
      end else begin
         if (wrAddr) begin
            ownBit0_q <= avsReq.writedata[0];
         end
         if (wrCtrl) begin
            wakeEn_q <= avsReq.writedata[BIT_WAKE];
         end
         if (wrMask) begin
            evMask_q <= avsReq.writedata[EV_W-1:0];
         end
         if (hitEv) begin
            dirFlag_q <= pinS.sda;
         end
         if (txAckRise) begin
            ackFlag_q <= pinS.sda;
         end
         if (hitEv) begin
            hitFlag_q <= 1'b1;
         end else if (startCond | rxLast | txAckRise) begin
            hitFlag_q <= 1'b0;
         end
         evStat_q <= evNext;
         irq <= |(evNext & (wrMask ? avsReq.writedata[EV_W-1:0] : evMask_q));
         wakeReq <= hitEv & wakeEn_q;
      end
   end

   // ==========================================================
   // checks
   property p_dir;
      @(posedge clk_sys) disable iff (rst) hitEv |=> (dirFlag_q == $past(pinS.sda)) && hitFlag_q;
   endproperty
   a_dir: assert property (p_dir) else $error("direction flag not latched on match");

   property p_ack;
      @(posedge clk_sys) disable iff (rst)
         (state_q == ST_ACK && sclFall && !sdaOe && !startCond && !stopCond) |=> sdaOe;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge not driven");

   property p_nomatch;
      @(posedge clk_sys) disable iff (rst) (addrLast && !addrMatch && !startCond) |=> state_q == ST_WAIT && !hitFlag_q;
   endproperty
   a_nomatch: assert property (p_nomatch) else $error("selected on a foreign address");

   property p_rxack;
      @(posedge clk_sys) disable iff (rst) txAckRise |=> ackFlag_q == $past(pinS.sda);
   endproperty
   a_rxack: assert property (p_rxack) else $error("acknowledge flag wrong");

   property p_release;
      @(posedge clk_sys) disable iff (rst) (nackEv && !stopCond) |=> (state_q == ST_WAIT) && !sdaOe;
   endproperty
   a_release: assert property (p_release) else $error("data line held after no acknowledge");

   property p_wake;
      @(posedge clk_sys) disable iff (rst) hitEv |=> wakeReq == $past(wakeEn_q);
   endproperty
   a_wake: assert property (p_wake) else $error("wake request wrong");

   property p_rxdata;
      @(posedge clk_sys) disable iff (rst) rxLast |=> dataReg_q == {$past(shQ[6:0]), $past(pinS.sda)};
   endproperty
   a_rxdata: assert property (p_rxdata) else $error("received byte not stored");

   property p_irq;
      @(posedge clk_sys) disable iff (rst) (hitEv && evMask_q[EV_HIT] && !wrMask) |=> irq [*2];
   endproperty
   a_irq: assert property (p_irq) else $error("no interrupt on match");

   property p_bus;
      @(posedge clk_sys) disable iff (rst) (busReq && waitQ) |=> !waitQ ##1 waitQ;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule

/* File: hdl/i2c_slave_pkg.sv */
// register map, field positions, reset values and carrier types of the two-wire slave
// assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses
package i2c_slave_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [4:0] OFS_DATA = 5'h00;
   localparam logic [4:0] OFS_ADDR = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_STAT = 5'h0C;
   localparam logic [4:0] OFS_MASK = 5'h10;
   // ==========================================================
   // control register fields (serial_control_one)
   localparam int BIT_ACK = 0;
   localparam int BIT_WAKE = 1;
   localparam int BIT_DIR = 2;
   localparam int BIT_HIT = 3;
   // ==========================================================
   // interrupt status and mask fields
   localparam int EV_HIT = 0;
   localparam int EV_BYTE = 1;
   localparam int EV_NACK = 2;
   localparam int EV_W = 3;
   // ==========================================================
   // reset values and counts
   localparam logic RST_ADDR_BIT0 = 1'b0;
   localparam logic RST_WAKE = 1'b0;
   localparam logic RST_ACK = 1'b1;
   localparam logic [EV_W-1:0] RST_EV = 3'h0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] ADDR_BITS = 4'h7;
   localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
   // ==========================================================
   // carrier types
   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [31:0] writedata;
   } avs_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avs_rsp_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } pins_t;
endpackage

/* File: hdl/pin_sync.sv */
// three-stage synchroniser with agreement filter, one per bit
// assumes asynchronous inputs; output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               s1_q[i] <= 1'b1;
               s2_q[i] <= 1'b1;
               s3_q[i] <= 1'b1;
               dout[i] <= 1'b1;
            end else begin
               s1_q[i] <= din[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) begin
                  dout[i] <= s3_q[i];
               end
            end
         end
      end
   endgenerate
endmodule

/* File: hdl/shift_byte.sv */
// eight-bit shifter, most significant bit first, with parallel load
// assumes the caller never asks for load and shift in one cycle; load wins
`timescale 1ns/1ps
module shift_byte (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic load,
   input wire logic [7:0] loadVal,
   input wire logic shiftEn,
   input wire logic bitIn,
   output logic [7:0] q
);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= 8'h00;
      end else if (load) begin
         q <= loadVal;
      end else if (shiftEn) begin
         q <= {q[6:0], bitIn};
      end
   end
endmodule

/* File: tb/i2c_master_model.sv */
// behavioural two-wire bus master driving the clock line and pulling the data line
// assumes the bench resolves the open-drain data line with a pull-up and feeds it back
`timescale 1ns/1ps
module i2c_master_model (
   output logic scl,
   output logic sdaLow,
   input wire logic sdaBus
);
   // ==========================================================
   // bit level, 160 ns per clock, clock idles high between frames
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   // pin changes land on clock edges, so they are non-blocking to avoid a sampling race
   task bitOut(input logic v);
      #40 sdaLow <= !v;
      #40 scl <= 1'b1;
      #80 scl <= 1'b0;
   endtask
   task bitIn(output logic v);
      #40 sdaLow <= 1'b0;
      #40 scl <= 1'b1;
      #40 v = sdaBus;
      #40 scl <= 1'b0;
   endtask
   // ==========================================================
   // frame level
   task start();
      #40 sdaLow <= 1'b1;
      #40 scl <= 1'b0;
   endtask
   task stop();
      #40 sdaLow <= 1'b1;
      #40 scl <= 1'b1;
      #40 sdaLow <= 1'b0;
      #40;
   endtask
   task wrByte(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bitOut(d[i]);
      end
      bitIn(ack);
   endtask
   task rdByte(output logic [7:0] d, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         bitIn(d[i]);
      end
      bitOut(nack);
   endtask
endmodule

/* File: tb/i2c_slave_address_data_status_tb_top.sv */
// self-checking bench: register access over Avalon-MM and two-wire transfers
// assumes the master model of i2c_master_model.sv on the far side
`timescale 1ns/1ps
module i2c_slave_address_data_status_tb_top;
   import i2c_slave_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   avs_req_t avsReq = '0;
   avs_rsp_t avsRsp;
   pins_t pins;
   logic sdaOut, sdaOe, irq, wakeReq, sclM, sdaLow, sdaBus, ack;
   logic [31:0] rd;
   logic [7:0] b;
   int err_count = 0;
   int samples_checked = 0;
   int wakeCnt = 0;
   always #4 clk_sys = ~clk_sys;
   // open-drain data line with pull-up
   assign sdaBus = !(sdaLow || (sdaOe && !sdaOut));
   assign pins = {sclM, sdaBus};
   always @(posedge clk_sys) if (wakeReq === 1'b1) wakeCnt <= wakeCnt + 1;
   i2c_slave_address_data_status dut_u (.clk_sys(clk_sys), .rst(rst), .avsReq(avsReq), .avsRsp(avsRsp),
      .pinIn(pins), .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq), .wakeReq(wakeReq));
   i2c_master_model mst_u (.scl(sclM), .sdaLow(sdaLow), .sdaBus(sdaBus));
   // ==========================================================
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      avsReq.read <= !wr;
      avsReq.write <= wr;
      avsReq.address <= a;
      avsReq.writedata <= wd;
      // waits for the answer however long it takes; only the watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (avsRsp.waitrequest !== 1'b0);
      rd = avsRsp.readdata;
      avsReq.read <= 1'b0;
      avsReq.write <= 1'b0;
   endtask
   task rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
      av(1'b0, a, 32'h0);
      chk(rd & m, exp);
   endtask
   // ==========================================================
   // scenarios
   task t_regs();
      rdc(OFS_ADDR, 32'h1, 32'h0);
      rdc(OFS_CTRL, 32'hF, 32'h1 << BIT_ACK);
      rdc(5'h14, 32'hFFFFFFFF, READ_UNMAPPED);
      av(1'b1, OFS_ADDR, 32'h55);
      rdc(OFS_ADDR, 32'hFFFFFFFF, 32'h55);
      av(1'b1, OFS_DATA, 32'h96);
      rdc(OFS_DATA, 32'hFFFFFFFF, 32'h96);
      av(1'b1, OFS_MASK, 32'h7);
      rdc(OFS_MASK, 32'hFFFFFFFF, 32'h7);
   endtask
   task t_write();
      av(1'b1, OFS_CTRL, 32'h1 << BIT_WAKE);
      mst_u.start();
      mst_u.wrByte(8'h54, ack);
      chk({31'h0, ack}, 32'h0);
      chk(32'(wakeCnt), 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdc(OFS_CTRL, 32'h6, 32'h1 << BIT_WAKE);
      rdc(OFS_STAT, 32'hFFFFFFFF, 32'h1 << EV_HIT);
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      mst_u.wrByte(8'hC3, ack);
      chk({31'h0, ack}, 32'h0);
      rdc(OFS_DATA, 32'hFFFFFFFF, 32'hC3);
      rdc(OFS_STAT, 32'hFFFFFFFF, 32'h1 << EV_BYTE);
      mst_u.stop();
   endtask
   task t_nomatch();
      mst_u.start();
      mst_u.wrByte(8'h56, ack);
      chk({31'h0, ack}, 32'h1);
      mst_u.stop();
      rdc(OFS_STAT, 32'hFFFFFFFF, 32'h0);
      av(1'b1, OFS_CTRL, 32'h0);
      mst_u.start();
      mst_u.wrByte(8'h54, ack);
      chk({31'h0, ack}, 32'h0);
      chk(32'(wakeCnt), 32'h1);
      mst_u.stop();
      rdc(OFS_STAT, 32'hFFFFFFFF, 32'h1 << EV_HIT);
   endtask
   task t_read();
      av(1'b1, OFS_DATA, 32'hA5);
      mst_u.start();
      mst_u.wrByte(8'h55, ack);
      chk({31'h0, ack}, 32'h0);
      rdc(OFS_CTRL, 32'h1 << BIT_DIR, 32'h1 << BIT_DIR);
      mst_u.rdByte(b, 1'b0);
      chk({24'h0, b}, 32'hA5);
      rdc(OFS_CTRL, 32'h1 << BIT_ACK, 32'h0);
      mst_u.rdByte(b, 1'b1);
      chk({24'h0, b}, 32'hA5);
      rdc(OFS_CTRL, 32'h1 << BIT_ACK, 32'h1 << BIT_ACK);
      rdc(OFS_STAT, 32'h5, 32'h5);
      mst_u.rdByte(b, 1'b1);
      chk({24'h0, b}, 32'hFF);
      mst_u.stop();
   endtask
   // ==========================================================
   // verdict
   task complete_run();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      err_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_write();
      t_nomatch();
      t_read();
      complete_run();
   end
endmodule
